// File: logic/pef_regs.svh
// timing counts, limits, widths and select codes of the periodic-error filter
`ifndef PEF_REGS_SVH
`define PEF_REGS_SVH

`define PEF_CLK_PERIOD_NS 10
`define PEF_MIN_INTERVAL_NS 1000000
`define PEF_MIN_INTERVAL_CYC (`PEF_MIN_INTERVAL_NS / `PEF_CLK_PERIOD_NS)
`define PEF_DEPTH_MIN 10'h001
`define PEF_DEPTH_MAX 10'h3E7
`define PEF_DEPTH_W 10
`define PEF_PERIOD_W 32
`define PEF_SEL_HOLD_CODE 2'h3

`endif

// File: logic/pef_pkg.sv
// front-panel selection types of the periodic-error filter
package pef_pkg;

  typedef enum logic [1:0] {
    bw_min,
    bw_mid,
    bw_max
  } pef_bw_t;

  typedef enum logic [1:0] {
    ofilt_1hz,
    ofilt_10hz,
    ofilt_100hz,
    wideband_setting
  } pef_ofilt_t;

  typedef enum logic [1:0] {
    gain_min,
    gain_mid,
    gain_max
  } pef_gain_t;

endpackage : pef_pkg

// File: logic/pef_meas_if.sv
// measured interval handed from the period meter to the averaging filter
`timescale 1ns/100ps
interface pef_meas_if #(
  parameter int PERIOD_W = 32
) ();
  logic [PERIOD_W-1:0] period;
  logic strobe;

  modport meter (output period, output strobe);
  modport filter (input period, input strobe);
endinterface : pef_meas_if

// File: logic/pef_period_meter.sv
// falling-edge interval meter with a saturating cycle counter restarted at each fall
`timescale 1ns/100ps
`include "pef_regs.svh"
module pef_period_meter #(
  parameter int PERIOD_W = `PEF_PERIOD_W
) (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic pulse_in, // shaped input pulse train
  pef_meas_if.meter meas // interval and its strobe
);

  typedef struct packed {
    logic prev;
    logic armed;
    logic [PERIOD_W-1:0] cnt;
    logic [PERIOD_W-1:0] period;
    logic strobe;
  } pef_meter_st_t;

  pef_meter_st_t st_ff;
  pef_meter_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe = 1'b0;
    nxt_st.prev = pulse_in;
    // saturate so a stalled input reads as a very long period, not a wrap
    if (st_ff.cnt != {PERIOD_W{1'b1}}) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
    if (st_ff.prev && !pulse_in) begin
      if (st_ff.armed) begin
        nxt_st.period = st_ff.cnt;
        nxt_st.strobe = 1'b1;
      end
      nxt_st.cnt = {{(PERIOD_W-1){1'b0}}, 1'b1};
      nxt_st.armed = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign meas.period = st_ff.period;
  assign meas.strobe = st_ff.strobe;

  a_strobe_on_fall: assert property (
    @(posedge core_clk) disable iff (rst)
    st_ff.strobe |-> $past(st_ff.prev) && !$past(pulse_in))
    else $error("interval strobe without a falling edge");

  a_count_period: assert property (
    @(posedge core_clk) disable iff (rst)
    st_ff.strobe |-> st_ff.period == $past(st_ff.cnt))
    else $error("reported interval differs from the counter");

endmodule : pef_period_meter

// File: logic/pef_filter.sv
// periodic-error averaging filter with output pacing and panel selections
`timescale 1ns/100ps
`include "pef_regs.svh"
module pef_filter #(
  parameter int PERIOD_W = `PEF_PERIOD_W,
  parameter int DEPTH_MAX = `PEF_DEPTH_MAX,
  parameter int MIN_INTERVAL_CYC = `PEF_MIN_INTERVAL_CYC
) (
  input wire logic core_clk, // system clock, 100 MHz
  input wire logic rst, // async reset, active high
  input wire logic pulse_in, // shaped input pulse train
  input wire logic [`PEF_DEPTH_W-1:0] averaging_depth, // pulses averaged
  input wire logic [1:0] bw_req, // requested input bandwidth code
  input wire logic [1:0] ofilt_req, // requested output filter code
  input wire logic [1:0] gain_req, // requested input gain code
  output logic [PERIOD_W-1:0] avg_period, // period in cycles toward the DAC
  output logic period_valid, // one-cycle pulse, new avg_period
  output logic averaging_active, // averaging path in use
  output logic suppression_full, // window holds depth pulses
  output pef_pkg::pef_bw_t bw_sel, // input bandwidth switch
  output pef_pkg::pef_ofilt_t ofilt_sel, // output filter switch
  output pef_pkg::pef_gain_t input_gain_select // input gain switch
);

  localparam int DW = `PEF_DEPTH_W;
  localparam int SUM_W = PERIOD_W + DW;
  localparam logic [PERIOD_W-1:0] MIN_CYC = PERIOD_W'(MIN_INTERVAL_CYC);
  localparam logic [31:0] GAP_OK = 32'(MIN_INTERVAL_CYC - 1);

  typedef struct packed {
    logic [DEPTH_MAX-1:0][PERIOD_W-1:0] ring;
    logic [DW-1:0] wr_idx;
    logic [DW-1:0] fill;
    logic [DW-1:0] depth;
    logic [SUM_W-1:0] sum;
    logic active;
    logic pending;
    logic [PERIOD_W-1:0] pend_val;
    logic [31:0] since_upd;
    logic [PERIOD_W-1:0] out_val;
    logic out_stb;
    pef_pkg::pef_bw_t bw;
    pef_pkg::pef_ofilt_t ofilt;
    pef_pkg::pef_gain_t gain;
  } pef_filt_st_t;

  pef_filt_st_t st_ff;
  pef_filt_st_t nxt_st;
  logic [DW-1:0] depth_n;
  logic [PERIOD_W-1:0] oldest;

  pef_meas_if #(.PERIOD_W(PERIOD_W)) meas ();

  pef_period_meter #(.PERIOD_W(PERIOD_W)) u_meter (
    .core_clk(core_clk),
    .rst(rst),
    .pulse_in(pulse_in),
    .meas(meas.meter)
  );

  function automatic logic [DW-1:0] clamp_depth(input logic [DW-1:0] d);
    if (d < `PEF_DEPTH_MIN) begin
      return `PEF_DEPTH_MIN;
    end else if (d > DW'(DEPTH_MAX)) begin
      return DW'(DEPTH_MAX);
    end
    return d;
  endfunction : clamp_depth

  function automatic logic sel_ok3(input logic [1:0] code);
    return code != `PEF_SEL_HOLD_CODE;
  endfunction : sel_ok3

  assign depth_n = clamp_depth(averaging_depth);
  assign oldest = (st_ff.fill == st_ff.depth) ? st_ff.ring[st_ff.wr_idx] : '0;

  always_comb begin
    logic [SUM_W-1:0] sum_new;
    logic [DW-1:0] fill_new;
    sum_new = '0;
    fill_new = '0;
    nxt_st = st_ff;
    nxt_st.out_stb = 1'b0;
    // a depth change restarts the window rather than mixing two lengths
    if (depth_n != st_ff.depth) begin
      nxt_st.depth = depth_n;
      nxt_st.fill = '0;
      nxt_st.wr_idx = '0;
      nxt_st.sum = '0;
      // depth 1 is averaging off at once, not only after the next pulse
      if (depth_n == `PEF_DEPTH_MIN) begin
        nxt_st.active = 1'b0;
      end
    end
    if (meas.strobe) begin
      if (meas.period < MIN_CYC || depth_n == `PEF_DEPTH_MIN) begin
        nxt_st.active = 1'b0;
        nxt_st.fill = '0;
        nxt_st.wr_idx = '0;
        nxt_st.sum = '0;
        nxt_st.pend_val = meas.period;
      end else begin
        nxt_st.active = 1'b1;
        if (depth_n != st_ff.depth) begin
          sum_new = SUM_W'(meas.period);
          fill_new = `PEF_DEPTH_MIN;
          nxt_st.wr_idx = (depth_n == `PEF_DEPTH_MIN) ? '0 : `PEF_DEPTH_MIN;
          nxt_st.ring[0] = meas.period;
        end else begin
          sum_new = st_ff.sum + SUM_W'(meas.period) - SUM_W'(oldest);
          fill_new = (st_ff.fill == st_ff.depth) ? st_ff.fill : st_ff.fill + 1'b1;
          nxt_st.ring[st_ff.wr_idx] = meas.period;
          nxt_st.wr_idx = (st_ff.wr_idx == st_ff.depth - 1'b1) ? '0 : st_ff.wr_idx + 1'b1;
        end
        nxt_st.sum = sum_new;
        nxt_st.fill = fill_new;
        nxt_st.pend_val = PERIOD_W'(sum_new / SUM_W'(fill_new));
      end
      nxt_st.pending = 1'b1;
    end
    // pacing: a newer period replaces a still-pending one
    if (nxt_st.pending && st_ff.since_upd >= GAP_OK) begin
      nxt_st.out_val = nxt_st.pend_val;
      nxt_st.out_stb = 1'b1;
      nxt_st.pending = 1'b0;
      nxt_st.since_upd = '0;
    end else if (st_ff.since_upd != 32'hFFFF_FFFF) begin
      nxt_st.since_upd = st_ff.since_upd + 1'b1;
    end
    // unused fourth code of a three-way switch keeps the last position
    if (sel_ok3(bw_req)) begin
      nxt_st.bw = pef_pkg::pef_bw_t'(bw_req);
    end
    nxt_st.ofilt = pef_pkg::pef_ofilt_t'(ofilt_req);
    if (sel_ok3(gain_req)) begin
      nxt_st.gain = pef_pkg::pef_gain_t'(gain_req);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.depth <= `PEF_DEPTH_MIN;
      st_ff.since_upd <= 32'hFFFF_FFFF;
      st_ff.ofilt <= pef_pkg::wideband_setting;
      st_ff.bw <= pef_pkg::bw_max;
      st_ff.gain <= pef_pkg::gain_max;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avg_period = st_ff.out_val;
  assign period_valid = st_ff.out_stb;
  assign averaging_active = st_ff.active;
  assign suppression_full = st_ff.active && st_ff.fill == st_ff.depth;
  assign bw_sel = st_ff.bw;
  assign ofilt_sel = st_ff.ofilt;
  assign input_gain_select = st_ff.gain;

  // helper: cycles since the previous output update
  logic [31:0] gap_cnt_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_cnt_ff <= 32'hFFFF_FFFF;
    end else if (period_valid) begin
      gap_cnt_ff <= '0;
    end else if (gap_cnt_ff != 32'hFFFF_FFFF) begin
      gap_cnt_ff <= gap_cnt_ff + 1'b1;
    end
  end

  a_update_spacing: assert property (
    @(posedge core_clk) disable iff (rst)
    period_valid |-> gap_cnt_ff >= GAP_OK)
    else $error("output updated sooner than 1 ms after the last");

  a_short_bypass: assert property (
    @(posedge core_clk) disable iff (rst)
    meas.strobe && meas.period < MIN_CYC |=> !averaging_active && st_ff.fill == '0)
    else $error("short interval did not bypass averaging");

  a_resume_avg: assert property (
    @(posedge core_clk) disable iff (rst)
    meas.strobe && meas.period >= MIN_CYC && depth_n > `PEF_DEPTH_MIN
    |=> averaging_active)
    else $error("averaging did not resume on a long interval");

  a_depth_one_off: assert property (
    @(posedge core_clk) disable iff (rst)
    meas.strobe && depth_n == `PEF_DEPTH_MIN |=> !averaging_active
    && st_ff.pend_val == $past(meas.period))
    else $error("depth 1 did not pass the raw period");

  a_first_sample: assert property (
    @(posedge core_clk) disable iff (rst)
    meas.strobe && meas.period >= MIN_CYC && depth_n > `PEF_DEPTH_MIN
    && st_ff.fill == '0 && depth_n == st_ff.depth
    |=> st_ff.pend_val == $past(meas.period) && st_ff.fill == 1)
    else $error("first averaged sample differs from its period");

  a_full_on_pulse: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(suppression_full) |-> $past(meas.strobe) || $past(depth_n) != $past(st_ff.depth))
    else $error("suppression became full without a new pulse");

  a_sliding_sum: assert property (
    @(posedge core_clk) disable iff (rst)
    meas.strobe && averaging_active && suppression_full && depth_n == st_ff.depth
    && meas.period >= MIN_CYC
    |=> st_ff.sum == $past(st_ff.sum) + SUM_W'($past(meas.period)) - SUM_W'($past(oldest))
    && suppression_full)
    else $error("window sum did not slide by one period");

  a_bw_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    bw_req == `PEF_SEL_HOLD_CODE |=> bw_sel == $past(bw_sel))
    else $error("bandwidth changed on the unused code");

  a_ofilt_follow: assert property (
    @(posedge core_clk) disable iff (rst)
    !rst |=> ofilt_sel == pef_pkg::pef_ofilt_t'($past(ofilt_req)))
    else $error("output filter did not follow its request");

  a_gain_follow: assert property (
    @(posedge core_clk) disable iff (rst)
    !rst && gain_req != `PEF_SEL_HOLD_CODE
    |=> input_gain_select == pef_pkg::pef_gain_t'($past(gain_req)))
    else $error("gain did not follow its request");

  // the edge that still samples reset high loads reset values, not requests
  a_bw_follow: assert property (
    @(posedge core_clk) disable iff (rst)
    !rst && bw_req != `PEF_SEL_HOLD_CODE |=> bw_sel == pef_pkg::pef_bw_t'($past(bw_req)))
    else $error("bandwidth did not follow its request");

  a_gain_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    gain_req == `PEF_SEL_HOLD_CODE |=> input_gain_select == $past(input_gain_select))
    else $error("gain changed on the unused code");

  a_raw_on_short: assert property (
    @(posedge core_clk) disable iff (rst)
    meas.strobe && meas.period < MIN_CYC |=> st_ff.pend_val == $past(meas.period))
    else $error("short interval did not pass the raw period");

  a_output_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    !period_valid |-> $stable(avg_period))
    else $error("output value changed without an update");

  a_single_update: assert property (
    @(posedge core_clk) disable iff (rst)
    period_valid |=> !period_valid)
    else $error("output update lasted more than one cycle");

  a_fill_bound: assert property (
    @(posedge core_clk) disable iff (rst)
    st_ff.fill <= st_ff.depth)
    else $error("window fill exceeds the depth");

  a_window_cleared: assert property (
    @(posedge core_clk) disable iff (rst)
    depth_n != st_ff.depth && !meas.strobe |=> st_ff.fill == '0)
    else $error("depth change did not clear the window");

  a_index_bound: assert property (
    @(posedge core_clk) disable iff (rst)
    st_ff.wr_idx < st_ff.depth)
    else $error("ring write index outside the window");

  a_depth_range: assert property (
    @(posedge core_clk) disable iff (rst)
    st_ff.depth >= `PEF_DEPTH_MIN && st_ff.depth <= DW'(DEPTH_MAX))
    else $error("held depth outside 1 to the maximum");

  a_active_depth: assert property (
    @(posedge core_clk) disable iff (rst)
    averaging_active |-> st_ff.depth > `PEF_DEPTH_MIN)
    else $error("averaging active with depth 1");

  c_bypass_then_resume: cover property (
    @(posedge core_clk) disable iff (rst)
    !averaging_active ##[1:1000] averaging_active);

  c_window_full: cover property (
    @(posedge core_clk) disable iff (rst)
    $rose(suppression_full));

  c_paced_update: cover property (
    @(posedge core_clk) disable iff (rst)
    period_valid && averaging_active);

  c_fast_bypass: cover property (
    @(posedge core_clk) disable iff (rst)
    meas.strobe && meas.period < MIN_CYC);

  c_full_update: cover property (
    @(posedge core_clk) disable iff (rst)
    period_valid && suppression_full);

endmodule : pef_filter

// File: verif/pef_pulse_src.sv
// shaped pulse source standing in for the signal conditioner
`timescale 1ns/100ps
module pef_pulse_src (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic run, // emit pulses while high
  input wire logic [31:0] gap, // cycles between falling edges
  output logic pulse_in // pulse train, idles high
);
  logic [31:0] cnt_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h0000_0000;
      pulse_in <= 1'b1;
    end else if (run) begin
      cnt_ff <= (cnt_ff >= gap - 32'h0000_0001) ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
      // one low cycle per gap: the rise must not count as a period
      pulse_in <= (cnt_ff < gap - 32'h0000_0001);
    end else begin
      pulse_in <= 1'b1;
    end
  end
endmodule : pef_pulse_src

// File: verif/periodic_error_averaging_filter_test.sv
// self-checking bench of the periodic-error averaging filter
`timescale 1ns/100ps
module periodic_error_averaging_filter_test;
  localparam int MIN_CYC = 20;
  logic core_clk, rst, pulse_in, run, seen;
  logic [31:0] gap, avg_period, got;
  logic [9:0] averaging_depth;
  logic [1:0] bw_req, ofilt_req, gain_req;
  logic period_valid, averaging_active, suppression_full;
  pef_pkg::pef_bw_t bw_sel;
  pef_pkg::pef_ofilt_t ofilt_sel;
  pef_pkg::pef_gain_t input_gain_select;
  int bad_count, compares, cyc, since;

  pef_pulse_src src (.core_clk(core_clk), .rst(rst), .run(run), .gap(gap), .pulse_in(pulse_in));
  pef_filter #(.MIN_INTERVAL_CYC(MIN_CYC)) dut (.core_clk(core_clk), .rst(rst),
    .pulse_in(pulse_in), .averaging_depth(averaging_depth), .bw_req(bw_req),
    .ofilt_req(ofilt_req), .gain_req(gain_req), .avg_period(avg_period),
    .period_valid(period_valid), .averaging_active(averaging_active),
    .suppression_full(suppression_full), .bw_sel(bw_sel), .ofilt_sel(ofilt_sel),
    .input_gain_select(input_gain_select));

  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] act, input logic [31:0] exp, input string what);
    compares++;
    if (act !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, act, exp);
    end
  endtask : check

  task automatic wait_upd(output logic [31:0] v);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (period_valid !== 1'b1 && n < 400);
    check({31'h0, period_valid}, 32'h0000_0001, "update seen");
    v = avg_period;
  endtask : wait_upd

  task automatic set_run(input logic [31:0] g, input logic [9:0] d);
    @(posedge core_clk);
    gap <= g;
    averaging_depth <= d;
    run <= 1'b1;
  endtask : set_run

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // pacing watch and hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (rst) begin
      seen = 1'b0;
    end else if (period_valid === 1'b1) begin
      if (seen && since < MIN_CYC - 1) begin
        bad_count++;
        $display("mismatch at %0t: updates too close", $time);
      end
      since = 0;
      seen = 1'b1;
    end else begin
      since++;
    end
    if (cyc > 20000) begin
      bad_count++;
      $display("mismatch at %0t: timeout", $time);
      final_report();
    end
  end

  initial begin
    rst = 1'b1;
    run = 1'b0;
    gap = 32'h0000_001e;
    averaging_depth = 10'h001;
    bw_req = 2'h0;
    ofilt_req = 2'h0;
    gain_req = 2'h0;
    repeat (11) @(posedge core_clk);
    #1;
    check(bw_sel, pef_pkg::bw_max, "bw reset");
    check(ofilt_sel, pef_pkg::wideband_setting, "ofilt reset");
    check(input_gain_select, pef_pkg::gain_max, "gain reset");
    check(avg_period, 32'h0000_0000, "avg reset");
    @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      bw_req <= i[1:0];
      ofilt_req <= i[1:0];
      gain_req <= i[1:0];
      @(posedge core_clk);
      #1;
      // code 3 on three-position selects keeps the last setting
      check(bw_sel, (i < 3) ? i : 2, "bw select");
      check(ofilt_sel, i, "ofilt select");
      check(input_gain_select, (i < 3) ? i : 2, "gain select");
    end
    set_run(32'h0000_001e, 10'h001);
    repeat (3) wait_upd(got);
    check(got, 32'h0000_001e, "depth one raw");
    check(averaging_active, 32'h0, "depth one bypass");
    set_run(32'h0000_001e, 10'h004);
    repeat (5) wait_upd(got);
    check(got, 32'h0000_001e, "steady average");
    check(averaging_active, 32'h1, "averaging on");
    check(suppression_full, 32'h1, "window full");
    set_run(32'h0000_0032, 10'h004);
    for (int k = 1; k <= 5; k++) begin
      wait_upd(got);
      check(got, 30 + 5 * ((k < 4) ? k : 4), "linear step");
    end
    check(averaging_active, 32'h1, "averaging continues");
    set_run(32'h0000_000a, 10'h004);
    repeat (4) wait_upd(got);
    check(got, 32'h0000_000a, "fast raw period");
    check(averaging_active, 32'h0, "fast bypass");
    check(suppression_full, 32'h0, "fast not full");
    set_run(32'h0000_0014, 10'h004);
    for (int k = 0; k < 6 && got !== 32'h0000_0014; k++) wait_upd(got);
    check(got, 32'h0000_0014, "slow again");
    check(averaging_active, 32'h1, "resumed at limit");
    check(suppression_full, 32'h0, "refill pending");
    repeat (3) wait_upd(got);
    check(suppression_full, 32'h1, "refilled");
    check(got, 32'h0000_0014, "refilled average");
    final_report();
  end
endmodule : periodic_error_averaging_filter_test
